/* rtl/itb_defines.svh */
// Purpose: Constants of the interval timer bus interface
// Assumes: Included by bare name from the count store and bus interface files
// Notes:   Definitions only
`ifndef ITB_DEFINES_SVH
`define ITB_DEFINES_SVH

// ----------------------------------------------------------------
// Port addresses and number of counters
// ----------------------------------------------------------------
`define ITB_ADDR_CTRL   2'h3
`define ITB_NUM_CNT     3

// ----------------------------------------------------------------
// Operating definition fields
// ----------------------------------------------------------------
`define ITB_SC_RANGE    7:6
`define ITB_RW_RANGE    5:4
`define ITB_MODE_RANGE  3:1
`define ITB_BCD_BIT     0
`define ITB_SC_READBACK 2'h3
`define ITB_FMT_LATCH   2'h0
`define ITB_FMT_LSB     2'h1
`define ITB_FMT_MSB     2'h2
`define ITB_FMT_BOTH    2'h3

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define ITB_NO_DATA     8'h00
`define ITB_ZERO8       8'h00
`define ITB_ZERO16      16'h0000
`define ITB_ONE16       16'h0001
`define ITB_MASK_LO     2'h1
`define ITB_MASK_HI     2'h2
`define ITB_MASK_ALL    2'h3
`define ITB_DEF_RESET   6'h00
`define ITB_NIB_ZERO    4'h0
`define ITB_NIB_NINE    4'h9
`define ITB_NIB_ONE     4'h1

`endif

/* rtl/itb_pkg.sv */
// Purpose: Types of the interval timer bus interface
// Assumes: Used with package scope only
// Notes:   No constants live here
package itb_pkg;
    // Which byte of a two byte access comes next
    typedef enum logic {
        itb_low_next,
        itb_high_next
    } itb_phase_type;

    // Per counter operating definition
    typedef struct packed {
        logic [2:0] mode;                   // Counting mode
        logic [1:0] fmt;                    // Access format
        logic       bcd;                    // Decimal counting
    } itb_def_type;
endpackage : itb_pkg

/* rtl/itb_store_if.sv */
// Purpose: Carrier between bus logic and count register store
// Assumes: One clock domain
// Notes:   Read data arrive one cycle after index
`timescale 1ns/10ps
`default_nettype none
interface itb_store_if;
    logic        wr_en;                     // Write a count register
    logic [1:0]  wr_idx;                    // Counter written
    logic [1:0]  wr_mask;                   // Byte lanes written
    logic [15:0] wr_data;                   // Write data
    logic [1:0]  rd_idx;                    // Counter read
    logic [15:0] rd_data;                   // Registered read data

    modport ctrl  (output wr_en, wr_idx, wr_mask, wr_data, rd_idx, input rd_data);
    modport store (input wr_en, wr_idx, wr_mask, wr_data, rd_idx, output rd_data);
endinterface : itb_store_if
`default_nettype wire

/* rtl/itb_count_store.sv */
// Purpose: Count registers of all counters
// Assumes: Writes and reads never need the same cycle ordering
// Notes:   Read data come from a register
`timescale 1ns/10ps
`default_nettype none
`include "itb_defines.svh"
module itb_count_store #(
    parameter int NUM = `ITB_NUM_CNT        // Number of counters
) (
    input  wire logic mclk_in,              // System clock
    input  wire logic sys_rst_in,           // Async reset, high
    itb_store_if.store st                   // Store port
);
    logic [15:0] mem [NUM];                 // Count registers

    // ------------------------------------------------------------
    // Byte lane writes
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (st.wr_en && st.wr_mask[0]) begin
            mem[st.wr_idx][7:0] <= st.wr_data[7:0];
        end
        if (st.wr_en && st.wr_mask[1]) begin
            mem[st.wr_idx][15:8] <= st.wr_data[15:8];
        end
    end

    // ------------------------------------------------------------
    // Registered read
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st.rd_data <= `ITB_ZERO16;
        end else begin
            st.rd_data <= mem[st.rd_idx];
        end
    end
endmodule : itb_count_store
`default_nettype wire

/* rtl/itb_bus_interface.sv */
// Purpose: Host bus interface and three counters of the interval timer
// Assumes: All host and counter pins synchronous to mclk_in
// Notes:   Every counter counts as mode 0 here; other modes left out
`timescale 1ns/10ps
`default_nettype none
`include "itb_defines.svh"
module itb_bus_interface #(
    parameter int NUM = `ITB_NUM_CNT        // Number of counters
) (
    input  wire logic       mclk_in,            // System clock
    input  wire logic       sys_rst_in,         // Async reset, high
    input  wire logic [1:0] port_select_in,     // Port address
    input  wire logic       chip_sel_n_in,      // Chip select, low
    input  wire logic       read_n_in,          // Read strobe, low
    input  wire logic       write_n_in,         // Write strobe, low
    input  wire logic [7:0] host_data_bus_in,   // Data bus in
    output logic      [7:0] host_data_bus_out,  // Data bus out
    output logic            host_data_bus_oe_out, // Data bus drive enable
    input  wire logic [2:0] cnt_clk_in,         // Counter clocks
    input  wire logic [2:0] cnt_gate_in,        // Counter gates
    output logic      [2:0] cnt_out_out         // Counter outputs
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    itb_store_if st ();                         // Store carrier

    logic                  wr_n_reg;            // Delayed write strobe
    logic                  rd_n_reg;            // Delayed read strobe
    logic                  cs_n_reg;            // Delayed chip select
    logic [1:0]            addr_reg;            // Delayed address
    logic [7:0]            data_reg;            // Delayed write data
    logic                  wr_take;             // Write strobe rise
    logic                  rd_end;              // Read strobe rise
    logic                  wr_done;             // Count fully written
    logic                  load_req_reg;        // Store read issued
    logic                  load_go_reg;         // Store data ready
    logic [1:0]            load_idx_reg;        // Counter to load
    logic [7:0]            rd_byte;             // Byte for the bus
    itb_pkg::itb_def_type  def_reg   [NUM];     // Definitions
    itb_pkg::itb_phase_type wph_reg  [NUM];     // Write byte phase
    itb_pkg::itb_phase_type rph_reg  [NUM];     // Read byte phase
    logic [15:0]           ce_reg    [NUM];     // Counting elements
    logic [NUM-1:0]        armed_reg;           // Count loaded
    logic [NUM-1:0]        clk_q_reg;           // Delayed counter clock
    logic [NUM-1:0]        out_reg;             // Counter outputs

    // Decimal or binary decrement of a count
    function automatic logic [15:0] itb_dec(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        logic        borrow;
        r      = v;
        borrow = 1'b1;
        if (!bcd) begin
            r = v - `ITB_ONE16;
        end else begin
            for (int n = 0; n < 4; n++) begin
                if (borrow) begin
                    if (r[n*4 +: 4] == `ITB_NIB_ZERO) begin
                        r[n*4 +: 4] = `ITB_NIB_NINE;
                    end else begin
                        r[n*4 +: 4] = r[n*4 +: 4] - `ITB_NIB_ONE;
                        borrow      = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction : itb_dec

    // ------------------------------------------------------------
    // Count register store
    // ------------------------------------------------------------
    itb_count_store #(
        .NUM        (NUM)
    ) u_store (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .st         (st)
    );

    // ------------------------------------------------------------
    // Bus sampling
    // ------------------------------------------------------------
    // Delay strobes, address and data one cycle
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_n_reg <= 1'b1;
            rd_n_reg <= 1'b1;
            cs_n_reg <= 1'b1;
            addr_reg <= `ITB_ADDR_CTRL;
            data_reg <= `ITB_ZERO8;
        end else begin
            wr_n_reg <= write_n_in;
            rd_n_reg <= read_n_in;
            cs_n_reg <= chip_sel_n_in;
            addr_reg <= port_select_in;
            data_reg <= host_data_bus_in;
        end
    end

    // Strobe edges qualified by chip select
    always_comb begin
        wr_take = write_n_in & ~wr_n_reg & ~cs_n_reg;
        rd_end  = read_n_in & ~rd_n_reg & ~cs_n_reg;
    end

    // ------------------------------------------------------------
    // Count writes into the store
    // ------------------------------------------------------------
    always_comb begin
        st.wr_en   = 1'b0;
        st.wr_idx  = addr_reg;
        st.wr_mask = `ITB_MASK_ALL;
        st.wr_data = {data_reg, data_reg};
        wr_done    = 1'b0;
        st.rd_idx  = load_idx_reg;
        if (wr_take && addr_reg != `ITB_ADDR_CTRL) begin
            st.wr_en = 1'b1;
            unique case (def_reg[addr_reg].fmt)
                // Single byte formats clear the other byte
                `ITB_FMT_LSB: begin
                    st.wr_data = {`ITB_ZERO8, data_reg};
                    wr_done    = 1'b1;
                end
                `ITB_FMT_MSB: begin
                    st.wr_data = {data_reg, `ITB_ZERO8};
                    wr_done    = 1'b1;
                end
                `ITB_FMT_BOTH: begin
                    if (wph_reg[addr_reg] == itb_pkg::itb_low_next) begin
                        st.wr_mask = `ITB_MASK_LO;
                    end else begin
                        st.wr_mask = `ITB_MASK_HI;
                        wr_done    = 1'b1;
                    end
                end
                // Never programmed: ignore count bytes
                default: begin
                    st.wr_en = 1'b0;
                end
            endcase
        end
    end

    // Two stage load from store into counting element
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            load_req_reg <= 1'b0;
            load_go_reg  <= 1'b0;
            load_idx_reg <= `ITB_ADDR_CTRL;
        end else begin
            load_req_reg <= wr_done;
            load_go_reg  <= load_req_reg;
            if (wr_done) begin
                load_idx_reg <= addr_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Per counter logic
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM; i++) begin : g_cnt
        logic sel;                              // Counter addressed
        logic cw_hit;                           // Definition for it
        logic tick;                             // Counter clock rise
        assign sel    = (addr_reg == 2'(i));
        assign cw_hit = wr_take && addr_reg == `ITB_ADDR_CTRL
                        && data_reg[`ITB_SC_RANGE] == 2'(i)
                        && data_reg[`ITB_SC_RANGE] != `ITB_SC_READBACK
                        && data_reg[`ITB_RW_RANGE] != `ITB_FMT_LATCH;
        assign tick   = cnt_clk_in[i] & ~clk_q_reg[i];

        // Definition and byte phases
        always_ff @(posedge mclk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                def_reg[i] <= `ITB_DEF_RESET;
                wph_reg[i] <= itb_pkg::itb_low_next;
                rph_reg[i] <= itb_pkg::itb_low_next;
            end else if (cw_hit) begin
                def_reg[i].mode <= data_reg[`ITB_MODE_RANGE];
                def_reg[i].fmt  <= data_reg[`ITB_RW_RANGE];
                def_reg[i].bcd  <= data_reg[`ITB_BCD_BIT];
                wph_reg[i]      <= itb_pkg::itb_low_next;
                rph_reg[i]      <= itb_pkg::itb_low_next;
            end else begin
                if (st.wr_en && sel && def_reg[i].fmt == `ITB_FMT_BOTH) begin
                    wph_reg[i] <= (wph_reg[i] == itb_pkg::itb_low_next)
                                  ? itb_pkg::itb_high_next : itb_pkg::itb_low_next;
                end
                if (rd_end && sel && def_reg[i].fmt == `ITB_FMT_BOTH) begin
                    rph_reg[i] <= (rph_reg[i] == itb_pkg::itb_low_next)
                                  ? itb_pkg::itb_high_next : itb_pkg::itb_low_next;
                end
            end
        end

        // Counting element and output
        always_ff @(posedge mclk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                ce_reg[i]    <= `ITB_ZERO16;
                armed_reg[i] <= 1'b0;
                clk_q_reg[i] <= 1'b0;
                out_reg[i]   <= 1'b0;
            end else begin
                clk_q_reg[i] <= cnt_clk_in[i];
                if (cw_hit) begin
                    armed_reg[i] <= 1'b0;
                    out_reg[i]   <= 1'b0;
                end else if (load_go_reg && load_idx_reg == 2'(i)) begin
                    ce_reg[i]    <= st.rd_data;
                    armed_reg[i] <= 1'b1;
                    out_reg[i]   <= 1'b0;
                end else if (armed_reg[i] && tick && cnt_gate_in[i]) begin
                    ce_reg[i] <= itb_dec(ce_reg[i], def_reg[i].bcd);
                    if (ce_reg[i] == `ITB_ONE16) begin
                        out_reg[i] <= 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------
    always_comb begin
        rd_byte = `ITB_NO_DATA;
        if (port_select_in != `ITB_ADDR_CTRL) begin
            unique case (def_reg[port_select_in].fmt)
                `ITB_FMT_MSB: rd_byte = ce_reg[port_select_in][15:8];
                `ITB_FMT_BOTH: begin
                    if (rph_reg[port_select_in] == itb_pkg::itb_high_next) begin
                        rd_byte = ce_reg[port_select_in][15:8];
                    end else begin
                        rd_byte = ce_reg[port_select_in][7:0];
                    end
                end
                default: rd_byte = ce_reg[port_select_in][7:0];
            endcase
        end
    end

    // Registered bus drive
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            host_data_bus_out    <= `ITB_NO_DATA;
            host_data_bus_oe_out <= 1'b0;
        end else begin
            host_data_bus_oe_out <= ~chip_sel_n_in & ~read_n_in;
            host_data_bus_out    <= rd_byte;
        end
    end

    // Counter outputs straight from flops
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_out_out <= 3'h0;
        end else begin
            // Copy of counter outputs
            cnt_out_out <= out_reg;
        end
    end
endmodule : itb_bus_interface
`default_nettype wire

/* test/itb_bus_asserts.sv */
// Purpose: Port checks of the interval timer bus block
// Assumes: Bound to itb_bus_interface
// Notes:   A write is taken at the strobe rise
`timescale 1ns/10ps
`default_nettype none
module itb_bus_asserts #(
    parameter int NUM = 3                       // Counters
) (
    input wire logic       mclk_in,             // System clock
    input wire logic       sys_rst_in,          // Async reset
    input wire logic [1:0] port_select_in,      // Port address
    input wire logic       chip_sel_n_in,       // Chip select
    input wire logic       read_n_in,           // Read strobe
    input wire logic       write_n_in,          // Write strobe
    input wire logic [7:0] host_data_bus_in,    // Bus in
    input wire logic [7:0] host_data_bus_out,   // Bus out
    input wire logic       host_data_bus_oe_out, // Drive enable
    input wire logic [2:0] cnt_clk_in,          // Counter clocks
    input wire logic [2:0] cnt_gate_in,         // Counter gates
    input wire logic [2:0] cnt_out_out          // Counter outputs
);
    // ------------------------------------------------------------
    // Helper history
    // ------------------------------------------------------------
    logic        wr_low_reg;                    // Selected write low
    logic [1:0]  ps_reg;                        // Last address
    logic [7:0]  dat_reg;                       // Last data
    logic [2:0]  clk_reg;                       // Last counter clocks
    logic [11:0] touch_hist_reg;                // Four cycles of writes
    logic [11:0] ev_hist_reg;                   // Four cycles of clocks
    logic [2:0]  touch;                         // Write aimed at counter
    wire logic   taken = write_n_in && wr_low_reg; // Strobe rise
    wire logic [2:0] ev = cnt_clk_in & ~clk_reg & cnt_gate_in; // Gated rise
    wire logic [2:0] touch_any = touch | touch_hist_reg[2:0] | touch_hist_reg[5:3]
                               | touch_hist_reg[8:6] | touch_hist_reg[11:9];
    wire logic [2:0] ev_any = ev | ev_hist_reg[2:0] | ev_hist_reg[5:3]
                            | ev_hist_reg[8:6] | ev_hist_reg[11:9];

    // Which counter a taken write may disturb
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            touch[i] = taken && (ps_reg == 2'(i) || (ps_reg == 2'h3
                       && dat_reg[7:6] == 2'(i) && dat_reg[5:4] != 2'h0));
        end
    end

    // Shift the bus and clock history
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_low_reg     <= 1'b0;
            ps_reg         <= 2'h0;
            dat_reg        <= 8'h00;
            clk_reg        <= 3'h0;
            touch_hist_reg <= 12'h000;
            ev_hist_reg    <= 12'h000;
        end else begin
            wr_low_reg     <= !write_n_in && !chip_sel_n_in;
            ps_reg         <= port_select_in;
            dat_reg        <= host_data_bus_in;
            clk_reg        <= cnt_clk_in;
            touch_hist_reg <= {touch_hist_reg[8:0], touch};
            ev_hist_reg    <= {ev_hist_reg[8:0], ev};
        end
    end

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    chk_oe_on_read: assert property ((!chip_sel_n_in && !read_n_in) |=> host_data_bus_oe_out)
        else $error("drive enable missing in read");
    chk_oe_only_read: assert property (host_data_bus_oe_out |-> $past(!chip_sel_n_in && !read_n_in))
        else $error("bus driven outside read");
    chk_cs_blocks_read: assert property ($past(chip_sel_n_in) |-> !host_data_bus_oe_out)
        else $error("bus driven while deselected");
    chk_def_reads_zero: assert property ((!chip_sel_n_in && !read_n_in && port_select_in == 2'h3)
        |=> host_data_bus_oe_out && host_data_bus_out == 8'h00)
        else $error("definition port returned data");
    chk_def_clears_out: assert property ((taken && ps_reg == 2'h3 && dat_reg[7:4] != 4'h0
        && dat_reg[7:6] == 2'h0 && dat_reg[5:4] != 2'h0) |-> ##[1:3] !cnt_out_out[0])
        else $error("definition left output high");
    chk_fall_needs_write: assert property ((~cnt_out_out & $past(cnt_out_out) & ~touch_any) == 3'h0)
        else $error("output fell without a write");
    chk_out_needs_clock: assert property ((cnt_out_out & ~$past(cnt_out_out) & ~ev_any) == 3'h0)
        else $error("output rose without its clock");
    chk_write_on_rise: assert property ((!write_n_in && !chip_sel_n_in)[*2] |-> $stable(cnt_out_out))
        else $error("output moved during write strobe");
endmodule : itb_bus_asserts

bind itb_bus_interface itb_bus_asserts #(.NUM(NUM)) u_chk (.mclk_in, .sys_rst_in,
    .port_select_in, .chip_sel_n_in, .read_n_in, .write_n_in, .host_data_bus_in,
    .host_data_bus_out, .host_data_bus_oe_out, .cnt_clk_in, .cnt_gate_in, .cnt_out_out);
`default_nettype wire

/* test/itb_host_model.sv */
// Purpose: Processor side of the timer data bus
// Assumes: Strobes change just after a rising edge
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module itb_host_model (
    input  wire logic       mclk_in,            // System clock
    input  wire logic [7:0] bus_in,             // Resolved data bus
    input  wire logic       bus_oe_in,          // Device drives bus
    output logic      [1:0] port_select_out,    // Port address
    output logic            chip_sel_n_out,     // Chip select, low
    output logic            read_n_out,         // Read strobe, low
    output logic            write_n_out,        // Write strobe, low
    output logic      [7:0] bus_out             // Host write data
);
    // Idle bus at time zero
    initial begin
        port_select_out = 2'h0;
        chip_sel_n_out  = 1'b1;
        read_n_out      = 1'b1;
        write_n_out     = 1'b1;
        bus_out         = 8'hA5;
    end

    task automatic write_port(input logic [1:0] addr, input logic [7:0] data,
                              input logic cs_n);
        @(posedge mclk_in);
        chip_sel_n_out  <= cs_n;
        port_select_out <= addr;
        bus_out         <= data;
        write_n_out     <= 1'b0;
        repeat (2) @(posedge mclk_in);
        write_n_out     <= 1'b1;
        @(posedge mclk_in);
        chip_sel_n_out  <= 1'b1;
        bus_out         <= ~data;
        repeat (3) @(posedge mclk_in);
    endtask : write_port

    task automatic read_port(input logic [1:0] addr, input logic cs_n,
                             output logic [7:0] data, output logic oe);
        @(posedge mclk_in);
        chip_sel_n_out  <= cs_n;
        port_select_out <= addr;
        read_n_out      <= 1'b0;
        repeat (2) @(posedge mclk_in);
        data = bus_in;
        oe   = bus_oe_in;
        read_n_out      <= 1'b1;
        @(posedge mclk_in);
        chip_sel_n_out  <= 1'b1;
        repeat (2) @(posedge mclk_in);
    endtask : read_port
endmodule : itb_host_model
`default_nettype wire

/* test/testbench.sv */
// Purpose: Self-checking bench of the interval timer bus block
// Assumes: Host model drives the bus, bench drives counter pins
// Notes:   Random low byte counts and decimal bit from a fixed seed; high byte only counts fixed at 0100
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic            mclk_in = 1'b0;            // System clock
    logic            sys_rst_in = 1'b1;         // Reset
    logic [2:0]      cnt_clk = 3'h0;            // Counter clocks
    logic [2:0]      cnt_gate = 3'h7;           // Counter gates
    wire logic [1:0] ps;                        // Port address
    wire logic       cs_n, rd_n, wr_n, oe;      // Strobes, enable
    wire logic [7:0] host_dq, dev_dq;           // Driven bytes
    wire logic [2:0] cnt_out;                   // Counter outputs
    wire logic [7:0] bus_w = oe ? dev_dq : host_dq; // Resolved bus
    int              num_errors = 0;            // Mismatches
    int              samples_checked = 0;       // Comparisons
    int              seed = 20;                 // Random seed
    int              cycles = 0;                // Cycle count
    logic [7:0]      rdat;                      // Read byte
    logic            roe;                       // Read enable seen
    logic [2:0]      done_mask = 3'h0;          // Counters expired
    logic [15:0]     cnt;                       // Count written
    logic [1:0]      fmt;                       // Access format
    logic            bcd;                       // Decimal counting
    int              n;                         // Low byte value

    itb_bus_interface #(.NUM(3)) DUT (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .port_select_in(ps), .chip_sel_n_in(cs_n), .read_n_in(rd_n), .write_n_in(wr_n),
        .host_data_bus_in(bus_w), .host_data_bus_out(dev_dq), .host_data_bus_oe_out(oe),
        .cnt_clk_in(cnt_clk), .cnt_gate_in(cnt_gate), .cnt_out_out(cnt_out));
    itb_host_model u_host (.mclk_in(mclk_in), .bus_in(bus_w), .bus_oe_in(oe),
        .port_select_out(ps), .chip_sel_n_out(cs_n), .read_n_out(rd_n),
        .write_n_out(wr_n), .bus_out(host_dq));

    // Free running clock
    initial begin
        forever #10 mclk_in = ~mclk_in;
    end

    // ------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------
    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_byte(input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t byte exp %h got %h", $time, exp, got);
        end
    endtask : check_byte

    task automatic check_bits(input logic [2:0] exp, input logic [2:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t flags exp %b got %b", $time, exp, got);
        end
    endtask : check_bits

    // Clock rises on one counter, then settle
    task automatic pulse(input int i, input int k);
        repeat (k) begin
            @(posedge mclk_in) cnt_clk <= 3'h1 << i;
            @(posedge mclk_in) cnt_clk <= 3'h0;
        end
        repeat (4) @(posedge mclk_in);
    endtask : pulse

    // Clock rises needed to reach terminal count
    function automatic int to_pulses(input logic [15:0] c, input logic d);
        if (!d) return int'(c);
        return c[15:12] * 1000 + c[11:8] * 100 + c[7:4] * 10 + c[3:0];
    endfunction : to_pulses

    // Watchdog on a hung run
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            num_errors++;
            $display("FAIL %0t timeout", $time);
            report_and_stop;
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        @(posedge mclk_in);
        check_bits(3'h0, {cnt_out[2:1], oe});
        for (int k = 0; k < 6; k++) begin
            fmt = 2'(k % 3 + 1);
            n   = 2 + ($random(seed) & 3);
            bcd = 1'($random(seed));
            cnt = (fmt == 2'h2) ? 16'h0100 : {8'h00, 8'(n)};
            u_host.write_port(2'h3, {2'(k / 2), fmt, 3'(k), bcd}, 1'b0);
            if (fmt != 2'h2) u_host.write_port(2'(k / 2), cnt[7:0], 1'b0);
            if (fmt != 2'h1) u_host.write_port(2'(k / 2), cnt[15:8], 1'b0);
            done_mask[k / 2] = 1'b0;
            u_host.read_port(2'(k / 2), 1'b0, rdat, roe);
            check_byte((fmt == 2'h2) ? cnt[15:8] : cnt[7:0], rdat);
            if (fmt == 2'h3) u_host.read_port(2'(k / 2), 1'b0, rdat, roe);
            if (fmt == 2'h3) check_byte(cnt[15:8], rdat);
            // Gate low holds the count
            cnt_gate[k / 2] <= 1'b0;
            pulse(k / 2, 1);
            cnt_gate <= 3'h7;
            pulse(k / 2, to_pulses(cnt, bcd) - 1);
            check_bits(done_mask, cnt_out);
            pulse(k / 2, 1);
            done_mask[k / 2] = 1'b1;
            check_bits(done_mask, cnt_out);
            $display("test %0d done", k);
        end
        u_host.write_port(2'h3, 8'h30, 1'b1);
        u_host.write_port(2'h3, 8'hF0, 1'b0);
        u_host.write_port(2'h3, 8'h00, 1'b0);
        check_bits(3'h7, cnt_out);
        u_host.read_port(2'h3, 1'b0, rdat, roe);
        check_byte(8'h00, rdat);
        check_bits(3'h1, {2'h0, roe});
        u_host.read_port(2'h0, 1'b1, rdat, roe);
        check_bits(3'h0, {2'h0, roe});
        $display("test refusals done");
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        @(posedge mclk_in);
        check_bits(3'h0, cnt_out);
        $display("test reset done");
        report_and_stop;
    end
endmodule : testbench
`default_nettype wire
